/* sim/rsac_codec_tb_top.sv */
/*
  Self-checking bench for the codec: register tasks, random and corner frames.
  Assumes the far-end model and the codec share mclk.
*/
`timescale 1ns/100ps
`include "rsac_defs.svh"
module rsac_codec_tb_top;
  import rsac_pkg::*;
  logic mclk, srst, slow, reg_wr, reg_rd, tx_valid, tx_ready, tx_bit, tx_last;
  logic rx_valid, rx_bit, rx_last, rx_done, rx_error;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, h, a, x;
  logic [63:0] pl;
  logic [3:0] sz;
  int errors, tests_run, t;
  rsac_codec u_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_bit(tx_bit), .tx_last(tx_last), .rx_valid(rx_valid),
    .rx_bit(rx_bit), .rx_last(rx_last), .rx_done(rx_done), .rx_error(rx_error));
  rsac_far_end u_far (.mclk(mclk), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_bit(tx_bit), .tx_last(tx_last), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .rx_last(rx_last));
  task automatic chk(input logic [147:0] got, input logic [147:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Returns {reserved, byte count, lane mask}; lane 0 is mask bit 7.
  function automatic logic [17:0] dec(logic wp, logic [3:0] s, logic w);
    logic [63:0] l;
    l = wp ? 64'h0c07031f0f3f7f00 : 64'hc0e030f8f0fcfeff;
    if (s < 4) return {1'b0, 9'h001, (wp ? 8'h08 : 8'h80) >> s};
    if (s < 11 || (s == 11 && !wp))
      return {1'b0, 9'((32'h23254678 >> (4 * (11 - s))) & 32'hf), l[8 * (11 - s) +: 8]};
    if (s == 11) return {1'b0, 9'h010, 8'h00};
    return {w && !(s == 12 || (wp && s != 14)), 9'(32 * (2 * (s - 12) + wp + 1)), 8'h00};
  endfunction
  function automatic logic [147:0] frm(logic [1:0] m, output int len);
    logic [147:0] f;
    f = {128'h0, h[3:0], h[7:4], h[11:8], h[23:16]};
    len = 52;
    if (m == 1) f = {f[131:0], x[15:0]};
    if (m == 2) f = {f[115:0], x};
    len += (m == 1) ? 16 : (m == 2) ? 32 : 0;
    f = {f[115:0], a[31:3], h[12], h[25:24]};
    if (h[3:0] == 4'h5) f = {f[83:0], pl};
    if (h[3:0] == 4'h5) len += 64;
    return f;
  endfunction
  task automatic tx_one(input logic [1:0] m);
    logic [147:0] f;
    logic [7:0] ln;
    int len;
    ln = 8'(dec(h[12], h[11:8], 1'b1));
    for (int j = 0; j < 8; j++) if (!ln[j]) pl[8 * j +: 8] = 8'h00;
    f = frm(m, len);
    wr(`RSAC_A_TXHDR, h | 32'hff00e000);
    wr(`RSAC_A_TXADDR, a);
    wr(`RSAC_A_TXXADDR, x);
    wr(`RSAC_A_TXDHI, pl[63:32]);
    wr(`RSAC_A_TXDLO, pl[31:0]);
    // The start strobe builds the header from the mode already held, so set it first.
    wr(`RSAC_A_CTRL, {26'h0, h[25:24], 1'b0, m, 1'b0});
    u_far.clr();
    wr(`RSAC_A_CTRL, {26'h0, h[25:24], 1'b0, m, 1'b1});
    rd(`RSAC_A_STAT);
    chk(d[0], 1'b1);
    for (int k = 0; k < 1500 && u_far.got == 0; k++) @(posedge mclk);
    #1 chk(tx_valid, 1'b0);
    chk(u_far.got, len);
    chk(u_far.cap & ((148'h1 << len) - 1), f);
  endtask
  task automatic rx_one(input logic [1:0] m);
    logic [147:0] f;
    logic [17:0] e;
    int len;
    e = dec(h[12], h[11:8], h[3:0] == 4'h5);
    f = frm(m, len);
    wr(`RSAC_A_CTRL, {29'h0, m, 1'b0});
    u_far.send(f, len);
    #1 chk(rx_done, h[3:0] != 4'h0);
    chk(rx_error, h[3:0] == 4'h9 || (h[3:0] == 4'h5 && e[17]));
    if (h[3:0] == 4'h2 || h[3:0] == 4'h5) begin
      rd(`RSAC_A_RXSIZE);
      if (h[11:8] < 11 || (h[11:8] == 11 && !h[12]))
        chk(d, {7'h0, e[17], 7'h0, e[16:0]});
      else if (e[17]) chk(d[24], 1'b1);
      else chk({d[24], d[16:8]}, e[17:8]);
      rd(`RSAC_A_RXHDR);
      chk(d, h);
      rd(`RSAC_A_RXADDR);
      chk(d, {a[31:3], 3'b000});
      rd(`RSAC_A_RXXADDR);
      chk(d, (m == 1) ? {16'h0, x[15:0]} : (m == 2) ? x : 32'h0);
    end
  endtask
  task automatic rnd();
    a = $urandom;
    x = $urandom;
    pl = {$urandom, $urandom};
  endtask
  task automatic stop_test();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    {srst, slow, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    srst = 1'b1;
    errors = 0;
    tests_run = 0;
    void'($urandom(42));
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rd(`RSAC_A_STAT);
    chk(d, 32'h0);
    rd(`RSAC_A_RXHDR);
    chk(d, 32'h0);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c);
    chk(d, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      rnd();
      slow = i[0];
      h[3:0] = $urandom_range(0, 1) ? 4'h5 : 4'h2;
      t = $urandom_range(0, 4);
      h[7:4] = (h[3:0] == 4'h2) ? ((t == 0) ? 4'h4 : 4'(11 + t)) : 4'((t < 2) ? 4 + t : 10 + t);
      h[12] = $urandom_range(0, 1);
      sz = (h[3:0] == 4'h2) ? 4'($urandom_range(0, 15)) : 4'($urandom_range(0, 11));
      h[11:8] = (h[3:0] == 4'h5 && h[12] && sz == 11) ? 4'ha : sz;
      h[23:16] = 8'($urandom);
      h[31:24] = {6'h0, 2'($urandom)};
      h[15:13] = 3'h0;
      tx_one(2'(i % 3));
    end
    $display("test transmit done");
    foreach (h[i]) h[i] = 1'b0;
    for (int i = 0; i < 3; i++) begin
      h = (i == 0) ? 32'h00000e45 : (i == 1) ? 32'h00000041 : 32'h00000042;
      u_far.clr();
      wr(`RSAC_A_CTRL, {29'h0, (i == 2) ? 2'b11 : 2'b00, 1'b0});
      wr(`RSAC_A_TXHDR, h);
      wr(`RSAC_A_CTRL, {29'h0, (i == 2) ? 2'b11 : 2'b00, 1'b1});
      rd(`RSAC_A_STAT);
      chk(d[1:0], 2'b10);
      repeat (60) @(posedge mclk);
      chk(u_far.got, 0);
      wr(`RSAC_A_STAT, 32'h0000000e);
    end
    $display("test refusal done");
    for (int i = 0; i < 66; i++) begin
      rnd();
      h = {6'h0, 2'($urandom), 8'($urandom), 3'h0, 5'(i), 4'h4, 4'h2};
      if (i >= 32) h[3:0] = 4'h5;
      if (i >= 64) h[3:0] = (i == 64) ? 4'h0 : 4'h9;
      rx_one(2'($urandom_range(0, 2)));
    end
    rd(`RSAC_A_STAT);
    chk(d[3:2], 2'b11);
    $display("test receive done");
    stop_test();
  end
endmodule

/* sim/rsac_far_end.sv */
/*
  Far-end model of the remote element: sinks transmit frames, sources receive frames.
  Assumes one mclk domain; the bench drives slow and calls clr and send.
*/
`timescale 1ns/100ps
module rsac_far_end (
  input wire logic mclk,
  input wire logic slow,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_bit,
  input wire logic tx_last,
  output logic rx_valid,
  output logic rx_bit,
  output logic rx_last
);
  logic [147:0] cap;
  int cnt;
  int got;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_bit = 1'b0;
    rx_last = 1'b0;
    cnt = 0;
    got = 0;
  end
  // A slow sink stalls at random, so the sender must hold each bit.
  always @(posedge mclk) begin
    tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
    if (tx_valid && tx_ready) begin
      cap <= {cap[146:0], tx_bit};
      cnt <= cnt + 1;
      if (tx_last) begin
        got <= cnt + 1;
      end
    end
  end
  task automatic clr();
    cnt = 0;
    got = 0;
  endtask
  task automatic send(input logic [147:0] f, input int len);
    for (int i = len - 1; i >= 0; i--) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_bit <= f[i];
      rx_last <= (i == 0);
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    // An idle line shows the inverse of its last bit, never a stale copy.
    rx_bit <= ~f[0];
  endtask
endmodule

/* src/rsac_codec.sv */
/*
  Request header codec: builds read and write request frames from
  registers and sends them MSB first as a bit stream, and parses received
  request frames into registers with size decode and error flags.
  Assumes tx and rx streams come from logic on mclk, and a register master
  that never issues read and write strobes together.
*/
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "rsac_defs.svh"
module rsac_codec
  import rsac_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_bit,
  output logic tx_last,
  input wire logic rx_valid,
  input wire logic rx_bit,
  input wire logic rx_last,
  output logic rx_done,
  output logic rx_error
);
  rsac_state_t state, next_state;
  logic [1:0] mode, next_mode;
  logic [1:0] xam, next_xam;
  logic [31:0] txhdr, next_txhdr;
  logic [31:0] txaddr, next_txaddr;
  logic [31:0] txxaddr, next_txxaddr;
  logic [63:0] txdata, next_txdata;
  logic [3:1] stat, next_stat;
  logic [83:0] sh, next_sh;
  logic [7:0] bcnt, next_bcnt;
  logic has_data, next_has_data;
  logic [147:0] rbuf, next_rbuf, nb;
  logic [7:0] rcnt, next_rcnt;
  logic [31:0] rxhdr, next_rxhdr;
  logic [31:0] rxaddr, next_rxaddr;
  logic [31:0] rxxaddr, next_rxxaddr;
  logic [31:0] rxsize, next_rxsize;
  logic next_rx_done, next_rx_error;
  logic [31:0] next_rdata;
  logic [7:0] tx_lanes, rx_lanes;
  logic [8:0] tx_bytes, rx_bytes;
  logic tx_rsv, rx_rsv;
  logic [63:0] tx_dmask;
  logic [83:0] hdr;
  logic [7:0] hlen, rhlen, rlen;
  logic [3:0] tx_ft, tx_tt, rx_ft, rx_tt, rx_sz;
  logic tx_tt_ok, tx_ok, go, busy, wr_ok, fire, rx_end;
  logic [28:0] rx_a;
  logic rx_wp;
  logic [1:0] rx_xam;
  logic [31:0] rx_xa;
  logic rx_ft_rsv, rx_known, rx_tt_bad, rx_bad;

  assign tx_ft = txhdr[`RSAC_H_FT];
  assign tx_tt = txhdr[`RSAC_H_TT];
  assign busy = (state != RSAC_IDLE);
  assign fire = tx_valid && tx_ready;
  assign rx_end = rx_valid && rx_last;

  rsac_size_dec u_tx_size (
    .wdptr(txhdr[`RSAC_H_WP]),
    .size(txhdr[`RSAC_H_SZ]),
    .is_write(tx_ft == `RSAC_FT_WRITE),
    .lanes(tx_lanes),
    .bytes(tx_bytes),
    .rsv(tx_rsv)
  );
  rsac_size_dec u_rx_size (
    .wdptr(rx_wp),
    .size(rx_sz),
    .is_write(rx_ft == `RSAC_FT_WRITE),
    .lanes(rx_lanes),
    .bytes(rx_bytes),
    .rsv(rx_rsv)
  );

  // Expand the lane mask to bits; lanes outside the mask are padded zero.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lane
      assign tx_dmask[8*gi +: 8] = {8{tx_lanes[gi]}};
    end
  endgenerate

  // Only read-class and write-class frames with legal codes are sent.
  always_comb begin
    tx_tt_ok = 1'b0;
    if (tx_ft == `RSAC_FT_READ) begin
      tx_tt_ok = (tx_tt == `RSAC_TT_PLAIN) || (tx_tt >= `RSAC_TT_ATOM_LO);
    end else if (tx_ft == `RSAC_FT_WRITE) begin
      tx_tt_ok = (tx_tt == `RSAC_TT_PLAIN) || (tx_tt == `RSAC_TT_NOTIFY) ||
                 ((tx_tt >= `RSAC_TT_ATOM_LO) && (tx_tt <= `RSAC_TT_W_ATOM_HI));
    end
  end
  assign tx_ok = tx_tt_ok && !tx_rsv && (mode != 2'b11);
  assign go = reg_wr && (reg_addr == `RSAC_A_CTRL) && reg_wdata[`RSAC_C_GO];
  assign wr_ok = reg_wr && !busy;

  // Header is left aligned; address field drops byte bits 2..0.
  always_comb begin
    case (mode)
      RSAC_M50: begin
        hdr = {txhdr[`RSAC_H_FT], tx_tt, txhdr[`RSAC_H_SZ], txhdr[`RSAC_H_TAG],
               txxaddr[15:0], txaddr[`RSAC_ADW], txhdr[`RSAC_H_WP], xam,
               16'h0000};
        hlen = `RSAC_HLEN50;
      end
      RSAC_M66: begin
        hdr = {txhdr[`RSAC_H_FT], tx_tt, txhdr[`RSAC_H_SZ], txhdr[`RSAC_H_TAG],
               txxaddr, txaddr[`RSAC_ADW], txhdr[`RSAC_H_WP], xam};
        hlen = `RSAC_HLEN66;
      end
      default: begin
        hdr = {txhdr[`RSAC_H_FT], tx_tt, txhdr[`RSAC_H_SZ], txhdr[`RSAC_H_TAG],
               txaddr[`RSAC_ADW], txhdr[`RSAC_H_WP], xam,
               32'h0000_0000};
        hlen = `RSAC_HLEN34;
      end
    endcase
  end

  // Transmit sequencer: header bits, then one payload double-word for writes.
  // A multi-word write sends one double-word; the size code is only a ceiling.
  always_comb begin
    next_state = state;
    next_sh = sh;
    next_bcnt = bcnt;
    next_has_data = has_data;
    case (state)
      RSAC_IDLE: begin
        if (go && tx_ok) begin
          next_state = RSAC_HDR;
          next_sh = hdr;
          next_bcnt = hlen;
          next_has_data = (tx_ft == `RSAC_FT_WRITE);
        end
      end
      RSAC_HDR: begin
        if (fire) begin
          next_sh = {sh[82:0], 1'b0};
          next_bcnt = bcnt - 8'd1;
          if (bcnt == 8'd1) begin
            if (has_data) begin
              next_state = RSAC_DATA;
              next_sh = {txdata & tx_dmask, 20'h00000};
              next_bcnt = `RSAC_DLEN;
            end else begin
              next_state = RSAC_IDLE;
            end
          end
        end
      end
      RSAC_DATA: begin
        if (fire) begin
          next_sh = {sh[82:0], 1'b0};
          next_bcnt = bcnt - 8'd1;
          if (bcnt == 8'd1) begin
            next_state = RSAC_IDLE;
          end
        end
      end
      default: next_state = RSAC_IDLE;
    endcase
  end
  assign tx_valid = busy;
  assign tx_bit = sh[83];
  assign tx_last = (bcnt == 8'd1) && ((state == RSAC_DATA) || ((state == RSAC_HDR) && !has_data));

  // Receive: bits fill a left-aligned buffer; extra bits past the end are dropped.
  always_comb begin
    nb = rbuf;
    next_rcnt = rcnt;
    if (rx_valid && (rcnt < `RSAC_RBUF_LEN)) begin
      nb[`RSAC_RBUF_TOP - rcnt] = rx_bit;
      next_rcnt = rcnt + 8'd1;
    end
    rlen = next_rcnt;
    next_rbuf = nb;
    if (rx_end) begin
      next_rbuf = '0;
      next_rcnt = 8'd0;
    end
  end

  // Field extraction follows the one system-wide address width setting.
  assign rx_ft = nb[`RSAC_R_FT];
  assign rx_tt = nb[`RSAC_R_TT];
  assign rx_sz = nb[`RSAC_R_SZ];
  always_comb begin
    case (mode)
      RSAC_M50: begin
        rx_a = nb[`RSAC_R50_A];
        rx_wp = nb[`RSAC_R50_WP];
        rx_xam = nb[`RSAC_R50_XAM];
        rx_xa = {16'h0000, nb[`RSAC_R50_XA]};
        rhlen = `RSAC_HLEN50;
      end
      RSAC_M66: begin
        rx_a = nb[`RSAC_R66_A];
        rx_wp = nb[`RSAC_R66_WP];
        rx_xam = nb[`RSAC_R66_XAM];
        rx_xa = nb[`RSAC_R66_XA];
        rhlen = `RSAC_HLEN66;
      end
      default: begin
        rx_a = nb[`RSAC_R34_A];
        rx_wp = nb[`RSAC_R34_WP];
        rx_xam = nb[`RSAC_R34_XAM];
        rx_xa = 32'h0000_0000;
        rhlen = `RSAC_HLEN34;
      end
    endcase
  end

  always_comb begin
    case (rx_ft)
      4'h1, 4'h3, 4'h4, 4'h7, 4'h9, 4'ha, 4'hb: rx_ft_rsv = 1'b1;
      default: rx_ft_rsv = 1'b0;
    endcase
    rx_known = (rx_ft == `RSAC_FT_READ) || (rx_ft == `RSAC_FT_WRITE);
    rx_tt_bad = 1'b0;
    if (rx_ft == `RSAC_FT_READ) begin
      rx_tt_bad = !((rx_tt == `RSAC_TT_PLAIN) || (rx_tt >= `RSAC_TT_ATOM_LO));
    end else if (rx_ft == `RSAC_FT_WRITE) begin
      rx_tt_bad = !((rx_tt == `RSAC_TT_PLAIN) || (rx_tt == `RSAC_TT_NOTIFY) ||
                    ((rx_tt >= `RSAC_TT_ATOM_LO) && (rx_tt <= `RSAC_TT_W_ATOM_HI)));
    end
    // Unused trailing bits are never inspected; only short frames matter.
    rx_bad = rx_ft_rsv || (rx_known && (rx_tt_bad || rx_rsv || (rlen < rhlen) ||
             (mode == 2'b11)));
  end

  // Register file and receive results.
  always_comb begin
    next_mode = mode;
    next_xam = xam;
    next_txhdr = txhdr;
    next_txaddr = txaddr;
    next_txxaddr = txxaddr;
    next_txdata = txdata;
    next_rxhdr = rxhdr;
    next_rxaddr = rxaddr;
    next_rxxaddr = rxxaddr;
    next_rxsize = rxsize;
    next_rx_done = 1'b0;
    next_rx_error = 1'b0;
    next_stat = stat;
    // Transmit settings are frozen while a frame is on the wire.
    if (wr_ok) begin
      case (reg_addr)
        `RSAC_A_CTRL: begin
          next_mode = reg_wdata[`RSAC_C_MODE];
          next_xam = reg_wdata[`RSAC_C_XAM];
        end
        `RSAC_A_TXHDR: next_txhdr = reg_wdata & 32'h00ff_1fff;
        `RSAC_A_TXADDR: next_txaddr = reg_wdata;
        `RSAC_A_TXXADDR: next_txxaddr = reg_wdata;
        `RSAC_A_TXDHI: next_txdata[63:32] = reg_wdata;
        `RSAC_A_TXDLO: next_txdata[31:0] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_wr && (reg_addr == `RSAC_A_STAT)) begin
      next_stat = stat & ~reg_wdata[`RSAC_S_W1C];
    end
    if (go && (busy || !tx_ok)) begin
      next_stat[`RSAC_S_REF] = 1'b1;
    end
    if (rx_end && (rx_ft != `RSAC_FT_IMPL)) begin
      next_rx_done = 1'b1;
      next_rx_error = rx_bad;
      next_stat[`RSAC_S_RXDONE] = 1'b1;
      if (rx_bad) begin
        next_stat[`RSAC_S_RXERR] = 1'b1;
      end
      next_rxhdr = {6'h00, rx_xam, nb[`RSAC_R_TAG], 3'h0, rx_wp, rx_sz, rx_tt, rx_ft};
      next_rxaddr = {rx_a, 3'b000};
      next_rxxaddr = rx_xa;
      next_rxsize = {7'h00, rx_rsv, 7'h00, rx_bytes, rx_lanes};
    end
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `RSAC_A_CTRL: next_rdata = {26'h0, xam, 1'b0, mode, 1'b0};
        `RSAC_A_TXHDR: next_rdata = txhdr;
        `RSAC_A_TXADDR: next_rdata = txaddr;
        `RSAC_A_TXXADDR: next_rdata = txxaddr;
        `RSAC_A_TXDHI: next_rdata = txdata[63:32];
        `RSAC_A_TXDLO: next_rdata = txdata[31:0];
        `RSAC_A_STAT: next_rdata = {28'h0, stat, busy};
        `RSAC_A_RXHDR: next_rdata = rxhdr;
        `RSAC_A_RXADDR: next_rdata = rxaddr;
        `RSAC_A_RXXADDR: next_rdata = rxxaddr;
        `RSAC_A_RXSIZE: next_rdata = rxsize;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= RSAC_IDLE;
      sh <= '0;
      bcnt <= 8'd0;
      has_data <= 1'b0;
      rbuf <= '0;
      rcnt <= 8'd0;
      mode <= 2'b00;
      xam <= 2'b00;
      txhdr <= 32'h0;
      txaddr <= 32'h0;
      txxaddr <= 32'h0;
      txdata <= 64'h0;
      stat <= 3'h0;
      rxhdr <= 32'h0;
      rxaddr <= 32'h0;
      rxxaddr <= 32'h0;
      rxsize <= 32'h0;
      rx_done <= 1'b0;
      rx_error <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      state <= next_state;
      sh <= next_sh;
      bcnt <= next_bcnt;
      has_data <= next_has_data;
      rbuf <= next_rbuf;
      rcnt <= next_rcnt;
      mode <= next_mode;
      xam <= next_xam;
      txhdr <= next_txhdr;
      txaddr <= next_txaddr;
      txxaddr <= next_txxaddr;
      txdata <= next_txdata;
      stat <= next_stat;
      rxhdr <= next_rxhdr;
      rxaddr <= next_rxaddr;
      rxxaddr <= next_rxxaddr;
      rxsize <= next_rxsize;
      rx_done <= next_rx_done;
      rx_error <= next_rx_error;
      reg_rdata <= next_rdata;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  property p_refuse_rsv;
    go && (state == RSAC_IDLE) && tx_rsv |=> (state == RSAC_IDLE) && stat[`RSAC_S_REF];
  endproperty
  a_refuse_rsv: assert property (p_refuse_rsv) else $error("reserved size was sent");

  property p_first_kind;
    go && tx_ok && (state == RSAC_IDLE) |=> tx_valid && (sh[83:80] == $past(tx_ft));
  endproperty
  a_first_kind: assert property (p_first_kind) else $error("frame does not start with kind");

  property p_rx_low_zero;
    rx_done |-> (rxaddr[2:0] == 3'b000);
  endproperty
  a_rx_low_zero: assert property (p_rx_low_zero) else $error("low address bits not zero");

  property p_pad_lanes;
    $rose(state == RSAC_DATA) |-> ((sh[83:20] & ~tx_dmask) == 64'h0);
  endproperty
  a_pad_lanes: assert property (p_pad_lanes) else $error("unused lanes not padded");

  property p_rx_rsv_kind;
    rx_end && rx_ft_rsv |=> rx_error && rx_done && stat[`RSAC_S_RXERR];
  endproperty
  a_rx_rsv_kind: assert property (p_rx_rsv_kind) else $error("reserved kind not flagged");

  property p_rx_impl;
    rx_end && (rx_ft == `RSAC_FT_IMPL) |=> !rx_done && !rx_error;
  endproperty
  a_rx_impl: assert property (p_rx_impl) else $error("impl frame not ignored");

  property p_byte_onehot;
    (tx_bytes == 9'h001) |-> $onehot(tx_lanes);
  endproperty
  a_byte_onehot: assert property (p_byte_onehot) else $error("single byte mask not one-hot");

  property p_wr_rsv;
    (tx_ft == `RSAC_FT_WRITE) && !txhdr[`RSAC_H_WP] &&
      (txhdr[`RSAC_H_SZ] == `RSAC_SZ_MULTI_W) |-> tx_rsv && (tx_lanes == 8'h00);
  endproperty
  a_wr_rsv: assert property (p_wr_rsv) else $error("reserved write size accepted");

  property p_read_no_data;
    $rose(state == RSAC_HDR) && (tx_ft == `RSAC_FT_READ) |-> !has_data;
  endproperty
  a_read_no_data: assert property (p_read_no_data) else $error("read frame has payload");
endmodule

/* src/rsac_defs.svh */
/*
  Constants for the request size and alignment codec: register byte
  offsets, register field positions, format and transaction codes, frame
  lengths and receive buffer field positions.
  Assumes it is included by its bare name from the codec sources.
*/
`ifndef RSAC_DEFS_SVH
`define RSAC_DEFS_SVH
`define RSAC_A_CTRL 8'h00
`define RSAC_A_TXHDR 8'h04
`define RSAC_A_TXADDR 8'h08
`define RSAC_A_TXXADDR 8'h0c
`define RSAC_A_TXDHI 8'h10
`define RSAC_A_TXDLO 8'h14
`define RSAC_A_STAT 8'h18
`define RSAC_A_RXHDR 8'h1c
`define RSAC_A_RXADDR 8'h20
`define RSAC_A_RXXADDR 8'h24
`define RSAC_A_RXSIZE 8'h28
`define RSAC_C_GO 0
`define RSAC_C_MODE 2:1
`define RSAC_C_XAM 5:4
`define RSAC_H_FT 3:0
`define RSAC_H_TT 7:4
`define RSAC_H_SZ 11:8
`define RSAC_H_WP 12
`define RSAC_H_TAG 23:16
`define RSAC_H_XAM 25:24
`define RSAC_S_BUSY 0
`define RSAC_S_REF 1
`define RSAC_S_RXERR 2
`define RSAC_S_RXDONE 3
`define RSAC_S_W1C 3:1
`define RSAC_FT_IMPL 4'h0
`define RSAC_FT_READ 4'h2
`define RSAC_FT_WRITE 4'h5
`define RSAC_TT_PLAIN 4'h4
`define RSAC_TT_NOTIFY 4'h5
`define RSAC_TT_ATOM_LO 4'hc
`define RSAC_TT_W_ATOM_HI 4'he
`define RSAC_SZ_MULTI_W 4'he
`define RSAC_HLEN34 8'd52
`define RSAC_HLEN50 8'd68
`define RSAC_HLEN66 8'd84
`define RSAC_DLEN 8'd64
`define RSAC_RBUF_LEN 8'd148
`define RSAC_RBUF_TOP 8'd147
`define RSAC_R_FT 147:144
`define RSAC_R_TT 143:140
`define RSAC_R_SZ 139:136
`define RSAC_R_TAG 135:128
`define RSAC_R34_A 127:99
`define RSAC_R34_WP 98
`define RSAC_R34_XAM 97:96
`define RSAC_R50_XA 127:112
`define RSAC_R50_A 111:83
`define RSAC_R50_WP 82
`define RSAC_R50_XAM 81:80
`define RSAC_R66_XA 127:96
`define RSAC_R66_A 95:67
`define RSAC_R66_WP 66
`define RSAC_R66_XAM 65:64
`define RSAC_ADW 31:3
`endif

/* src/rsac_pkg.sv */
/*
  Types shared by the request size and alignment codec.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rsac_pkg;
  typedef enum logic [2:0] {
    RSAC_IDLE = 3'b001,
    RSAC_HDR = 3'b010,
    RSAC_DATA = 3'b100
  } rsac_state_t;
  typedef enum logic [1:0] {
    RSAC_M34 = 2'b00,
    RSAC_M50 = 2'b01,
    RSAC_M66 = 2'b10
  } rsac_mode_t;
endpackage

/* src/rsac_size_dec.sv */
/*
  Word-pointer and size-code decoder: lane mask, byte count and a flag
  for reserved combinations, for reads and for writes.
  Assumes purely combinational use by the codec core.
*/
`timescale 1ns/100ps
module rsac_size_dec (
  input wire logic wdptr,
  input wire logic [3:0] size,
  input wire logic is_write,
  output logic [7:0] lanes,
  output logic [8:0] bytes,
  output logic rsv
);
  // Mask bit 7 is lane 0, the most significant byte of the double-word.
  always_comb begin
    lanes = 8'h00;
    bytes = 9'h000;
    rsv = 1'b0;
    case (size)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        lanes = 8'h80 >> {wdptr, size[1:0]};
        bytes = 9'h001;
      end
      4'h4: begin
        lanes = wdptr ? 8'h0c : 8'hc0;
        bytes = 9'h002;
      end
      4'h5: begin
        lanes = wdptr ? 8'h07 : 8'he0;
        bytes = 9'h003;
      end
      4'h6: begin
        lanes = wdptr ? 8'h03 : 8'h30;
        bytes = 9'h002;
      end
      4'h7: begin
        lanes = wdptr ? 8'h1f : 8'hf8;
        bytes = 9'h005;
      end
      4'h8: begin
        lanes = wdptr ? 8'h0f : 8'hf0;
        bytes = 9'h004;
      end
      4'h9: begin
        lanes = wdptr ? 8'h3f : 8'hfc;
        bytes = 9'h006;
      end
      4'ha: begin
        lanes = wdptr ? 8'h7f : 8'hfe;
        bytes = 9'h007;
      end
      4'hb: begin
        lanes = 8'hff;
        bytes = wdptr ? 9'h010 : 9'h008;
      end
      default: begin
        lanes = 8'hff;
        if (!is_write) begin
          bytes = {4'({1'b0, size[1:0], wdptr} + 4'h1), 5'h00};
        end else if (wdptr) begin
          case (size)
            4'hc: bytes = 9'h040;
            4'hd: bytes = 9'h080;
            4'hf: bytes = 9'h100;
            default: rsv = 1'b1;
          endcase
        end else if (size == 4'hc) begin
          bytes = 9'h020;
        end else begin
          rsv = 1'b1;
        end
        if (rsv) begin
          lanes = 8'h00;
        end
      end
    endcase
  end
endmodule
